// >>> core/dacrc_defs.svh
// Timing counts and field constants for the dual converter controller
`ifndef DACRC_DEFS_SVH
`define DACRC_DEFS_SVH

// ****************************************
// Timing figures (ns) and derived counts
// ****************************************
`define DACRC_CLK_NS        25
`define DACRC_CONV_NS       5200
`define DACRC_QUIET_NS      400
`define DACRC_RD_LOW_NS     50
`define DACRC_RD_HIGH_NS    50
`define DACRC_SEL_SETUP_NS  500
`define DACRC_WAKE_EXT_NS   4800
`define DACRC_WAKE_INT_NS   5000000
// Least times round up
`define DACRC_CONV_CYC  ((`DACRC_CONV_NS + `DACRC_CLK_NS - 1) / `DACRC_CLK_NS)
`define DACRC_QUIET_CYC ((`DACRC_QUIET_NS + `DACRC_CLK_NS - 1) / `DACRC_CLK_NS)
`define DACRC_RDL_CYC   ((`DACRC_RD_LOW_NS + `DACRC_CLK_NS - 1) / `DACRC_CLK_NS)
`define DACRC_RDH_CYC \
	((`DACRC_RD_HIGH_NS + `DACRC_CLK_NS - 1) / `DACRC_CLK_NS)
`define DACRC_SEL_CYC \
	((`DACRC_SEL_SETUP_NS + `DACRC_CLK_NS - 1) / `DACRC_CLK_NS)
`define DACRC_WAKE_EXT_CYC \
	((`DACRC_WAKE_EXT_NS + `DACRC_CLK_NS - 1) / `DACRC_CLK_NS)
`define DACRC_WAKE_INT_CYC \
	((`DACRC_WAKE_INT_NS + `DACRC_CLK_NS - 1) / `DACRC_CLK_NS)

// ****************************************
// Data layout
// ****************************************
`define DACRC_DATA_W   14
`define DACRC_FIFO_D   8
`define DACRC_CNT_W    24

`endif

// >>> core/dacrc_pkg.sv
// Types shared by the dual converter controller
package dacrc_pkg;

	// One result word as it leaves the controller
	typedef struct packed {
		logic        pair_select; // Pair that was converted
		logic        second;      // Second input of the pair
		logic [13:0] code;        // Raw 14-bit code
	} dacrc_word_t;

	// Per-conversion request from the user side
	typedef struct packed {
		logic pair_select; // Pair to convert
		logic sleep;       // Auto-sleep after this conversion
		logic read_first;  // Fetch first input result
		logic read_second; // Fetch second input result
	} dacrc_req_t;

	// Sequencer states, one-hot
	typedef enum logic [8:0] {
		DACRC_IDLE  = 9'b0_0000_0001,
		DACRC_SETUP = 9'b0_0000_0010,
		DACRC_START = 9'b0_0000_0100,
		DACRC_BUSY  = 9'b0_0000_1000,
		DACRC_CSLO  = 9'b0_0001_0000,
		DACRC_RDLO  = 9'b0_0010_0000,
		DACRC_RDHI  = 9'b0_0100_0000,
		DACRC_QUIET = 9'b0_1000_0000,
		DACRC_WAKE  = 9'b1_0000_0000
	} dacrc_state_t;

endpackage

// >>> core/dacrc_fifo.sv
// Result FIFO with valid/ready on both sides
`timescale 1ns/10ps
module dacrc_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input  wire logic             mclk_i,
	input  wire logic             rst_n_i,
	// Fill side
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	// Drain side
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic [AW-1:0]    next_wr_ptr;
	logic [AW-1:0]    next_rd_ptr;
	logic [AW:0]      next_count;
	logic             push;
	logic             pop;

	// Pointer wrap for any depth
	function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
		bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	assign in_ready_o  = (count != (AW+1)'(DEPTH));
	assign out_valid_o = (count != '0);
	assign out_data_o  = mem[rd_ptr];
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;

	// Next pointers and fill level
	always_comb begin
		next_wr_ptr = push ? bump(wr_ptr) : wr_ptr;
		next_rd_ptr = pop ? bump(rd_ptr) : rd_ptr;
		next_count  = count + (AW+1)'(push) - (AW+1)'(pop);
	end

	// Storage has no reset; only the pointers matter
	always_ff @(posedge mclk_i) begin
		if (push) begin
			mem[wr_ptr] <= in_data_i;
		end
	end

	// Register pointers
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count  <= next_count;
		end
	end
endmodule

// >>> core/dacrc_ctrl.sv
// Host-side controller that runs the dual converter over its pins
`timescale 1ns/10ps
`include "dacrc_defs.svh"

// Behaviour
// - Host holds chip-select low and pulses read twice for 14-bit results.
// - Host ends the read at least 400 ns before next start edge.
// - Host read of both results takes about 450 ns.
// - Start low at conversion end selects auto-sleep; high selects normal.
// - Host may read only one result of a pair before sleeping.
// - Pair-select changes after start rises, 500 ns before next fall.
// - Host avoids reads while busy is high.
module dacrc_ctrl
	import dacrc_pkg::*;
#(
	parameter int WAKE_CYC  = `DACRC_WAKE_INT_CYC,
	parameter int FIFO_W    = 16,
	parameter int FIFO_D    = `DACRC_FIFO_D
) (
	// Clock and reset
	input  wire logic              mclk_i,
	input  wire logic              rst_n_i,
	// User request
	input  wire logic              req_valid_i,
	input  wire dacrc_req_t        req_i,
	input  wire logic              int_ref_i,
	output logic                   req_ready_o,
	// User result stream
	output logic                   res_valid_o,
	input  wire logic              res_ready_i,
	output dacrc_word_t            res_o,
	// Converter pins
	output logic                   convert_start_n_o,
	output logic                   pair_select_o,
	output logic                   cs_n_o,
	output logic                   rd_n_o,
	input  wire logic              busy_i,
	input  wire logic [13:0]       db_i
);
	// ****************************************
	// Pin synchronisers and state
	// ****************************************
	localparam int CW = `DACRC_CNT_W;

	logic              busy_m;
	logic              busy_s;
	logic [13:0]       db_m;
	logic [13:0]       db_s;
	dacrc_state_t      state;
	dacrc_state_t      next_state;
	logic [CW-1:0]     cnt;
	logic [CW-1:0]     next_cnt;
	dacrc_req_t        cur;
	dacrc_req_t        next_cur;
	logic              second;
	logic              next_second;
	logic              asleep;
	logic              next_asleep;
	logic              cvs_n;
	logic              next_cvs_n;
	logic              sel;
	logic              next_sel;
	logic              cs_n;
	logic              next_cs_n;
	logic              rd_n;
	logic              next_rd_n;
	logic              req_rdy;
	logic              next_req_rdy;
	logic              f_valid;
	logic              f_ready;
	dacrc_word_t       f_word;
	logic              res_valid_w;
	logic [FIFO_W-1:0] res_data_w;
	logic              wait_on;

	// Two flip-flops before any logic reads a pin
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			busy_m <= 1'b0;
			busy_s <= 1'b0;
			db_m   <= '0;
			db_s   <= '0;
		end else begin
			busy_m <= busy_i;
			busy_s <= busy_m;
			db_m   <= db_i;
			db_s   <= db_m;
		end
	end

	// Wake time chosen by reference source
	function automatic logic [CW-1:0] wake_cnt(input logic int_ref);
		wake_cnt = int_ref ? CW'(WAKE_CYC) : CW'(`DACRC_WAKE_EXT_CYC);
	endfunction

	// Read strobes wanted for a request
	function automatic logic reads_left(input dacrc_req_t r,
		input logic sec);
		reads_left = sec ? r.read_second : (r.read_first || r.read_second);
	endfunction

	// ****************************************
	// Sequencer next state
	// ****************************************
	always_comb begin
		next_state   = state;
		next_cnt     = (cnt != '0) ? cnt - 1'b1 : cnt;
		next_cur     = cur;
		next_second  = second;
		next_asleep  = asleep;
		next_cvs_n   = cvs_n;
		next_sel     = sel;
		next_cs_n    = cs_n;
		next_rd_n    = rd_n;
		next_req_rdy = 1'b0;
		f_valid      = 1'b0;
		f_word       = '{pair_select: cur.pair_select, second: second,
			code: db_s};
		wait_on      = (cnt != '0);
		unique case (state)
			DACRC_IDLE: begin
				next_req_rdy = !asleep || cvs_n;
				if (req_valid_i && req_rdy) begin
					next_req_rdy = 1'b0;
					next_cur     = req_i;
					next_sel     = req_i.pair_select;
					next_cnt     = CW'(`DACRC_SEL_CYC);
					if (asleep) begin
						// Rising edge wakes a sleeping part
						next_cvs_n = 1'b1;
					end
					next_state = DACRC_SETUP;
				end else if (asleep) begin
					// Raise start early so wake runs while idle
					next_cvs_n = 1'b1;
				end
			end
			DACRC_SETUP: begin
				if (!wait_on) begin
					next_cvs_n = 1'b0;
					next_state = asleep ? DACRC_WAKE : DACRC_START;
					next_cnt   = asleep ? wake_cnt(int_ref_i) : '0;
				end
			end
			DACRC_WAKE: begin
				// Busy seen early means the part woke before the wake count ran out
				if (!wait_on || busy_s) begin
					next_asleep = 1'b0;
					next_state  = DACRC_START;
				end
			end
			DACRC_START: begin
				// Keep start low briefly, then release for normal mode
				if (busy_s) begin
					next_cnt   = CW'(`DACRC_CONV_CYC);
					next_cvs_n = !cur.sleep;
					next_state = DACRC_BUSY;
				end
			end
			DACRC_BUSY: begin
				// Wait for busy low; reads refused meanwhile
				if (!busy_s) begin
					next_asleep = cur.sleep;
					next_second = 1'b0;
					if (reads_left(cur, 1'b0)) begin
						next_cs_n  = 1'b0;
						next_cnt   = '0;
						next_state = DACRC_CSLO;
					end else begin
						next_cnt   = CW'(`DACRC_QUIET_CYC);
						next_state = DACRC_QUIET;
					end
				end
			end
			DACRC_CSLO: begin
				if (f_ready) begin
					next_rd_n  = 1'b0;
					next_cnt   = CW'(`DACRC_RDL_CYC + 2);
					next_state = DACRC_RDLO;
				end
			end
			DACRC_RDLO: begin
				// Extra cycles cover the data synchroniser
				if (!wait_on) begin
					// Skip storing the first when only second wanted
					f_valid   = second ? cur.read_second
						: cur.read_first;
					next_rd_n  = 1'b1;
					next_cnt   = CW'(`DACRC_RDH_CYC);
					next_state = DACRC_RDHI;
				end
			end
			DACRC_RDHI: begin
				if (!wait_on) begin
					if (!second && reads_left(cur, 1'b1)) begin
						next_second = 1'b1;
						next_state  = DACRC_CSLO;
					end else begin
						next_cs_n  = 1'b1;
						next_cnt   = CW'(`DACRC_QUIET_CYC);
						next_state = DACRC_QUIET;
					end
				end
			end
			DACRC_QUIET: begin
				if (!wait_on) begin
					next_req_rdy = !asleep;
					next_state   = DACRC_IDLE;
				end
			end
		endcase
	end

	// Register sequencer state
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state   <= DACRC_IDLE;
			cnt     <= '0;
			cur     <= '0;
			second  <= 1'b0;
			asleep  <= 1'b0;
			cvs_n   <= 1'b1;
			sel     <= 1'b0;
			cs_n    <= 1'b1;
			rd_n    <= 1'b1;
			req_rdy <= 1'b0;
		end else begin
			state   <= next_state;
			cnt     <= next_cnt;
			cur     <= next_cur;
			second  <= next_second;
			asleep  <= next_asleep;
			cvs_n   <= next_cvs_n;
			sel     <= next_sel;
			cs_n    <= next_cs_n;
			rd_n    <= next_rd_n;
			req_rdy <= next_req_rdy;
		end
	end

	// ****************************************
	// Result buffer and registered outputs
	// ****************************************
	// Codes pass unchanged; coding depends on range version
	dacrc_fifo #(
		.WIDTH (FIFO_W),
		.DEPTH (FIFO_D)
	) u_fifo (
		.mclk_i      (mclk_i),
		.rst_n_i     (rst_n_i),
		.in_valid_i  (f_valid),
		.in_ready_o  (f_ready),
		.in_data_i   (f_word),
		.out_valid_o (res_valid_w),
		.out_ready_i (res_ready_i && !res_valid_o),
		.out_data_o  (res_data_w)
	);

	// Output register stage; one word per two cycles keeps it simple
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			res_valid_o <= 1'b0;
			res_o       <= '0;
		end else if (res_valid_o) begin
			res_valid_o <= !res_ready_i;
		end else begin
			res_valid_o <= res_valid_w && res_ready_i;
			res_o       <= res_data_w;
		end
	end

	assign convert_start_n_o = cvs_n;
	assign pair_select_o     = sel;
	assign cs_n_o            = cs_n;
	assign rd_n_o            = rd_n;
	assign req_ready_o       = req_rdy;
endmodule

// >>> bench/dacrc_ctrl_sva.sv
// Checker on the converter pins of the controller
`timescale 1ns/10ps
module dacrc_ctrl_sva (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// Converter pins
	input wire logic convert_start_n_o,
	input wire logic pair_select_o,
	input wire logic cs_n_o,
	input wire logic rd_n_o,
	input wire logic busy_i
);
	// ****************************************
	// Helper counters
	// ****************************************
	logic [7:0] quiet, next_quiet, held, next_held;
	logic [1:0] rds, next_rds;
	logic       sel_q, rd_q;

	// Cycles since read end, since select change; strobes in one read
	always_comb begin
		next_quiet = !cs_n_o ? 8'h00 : quiet + {7'h00, quiet != 8'hff};
		next_held = held + {7'h00, held != 8'hff};
		if (pair_select_o != sel_q) begin
			next_held = 8'h01;
		end
		next_rds = cs_n_o ? 2'h0 : rds + {1'b0, rd_q & !rd_n_o};
	end

	// Quiet and held counters start saturated so the first start is not flagged
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			quiet <= 8'hff;
			held <= 8'hff;
			rds <= 2'h0;
			sel_q <= 1'b0;
			rd_q <= 1'b1;
		end else begin
			quiet <= next_quiet;
			held <= next_held;
			rds <= next_rds;
			sel_q <= pair_select_o;
			rd_q <= rd_n_o;
		end
	end

	// ****************************************
	// Pin assertions
	// ****************************************
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);

	a_no_read_busy: assert property (!rd_n_o |-> !busy_i)
		else $error("read strobe while busy");
	a_read_in_select: assert property (!rd_n_o |-> !cs_n_o)
		else $error("read strobe outside chip select");
	a_strobe_count: assert property (
		$rose(cs_n_o) |-> rds inside {2'h1, 2'h2})
		else $error("wrong strobe count in one read");
	a_quiet_gap: assert property (
		$fell(convert_start_n_o) |-> quiet >= 8'h10)
		else $error("start too soon after read");
	a_select_setup: assert property (
		$fell(convert_start_n_o) |-> held >= 8'h14)
		else $error("pair select changed too late");
	a_select_start: assert property (
		$changed(pair_select_o) |-> convert_start_n_o)
		else $error("pair select changed while start low");
	a_strobe_low: assert property ($fell(rd_n_o) |-> !rd_n_o [*2])
		else $error("read strobe too short");
	a_strobe_gap: assert property (
		$rose(rd_n_o) && !cs_n_o |-> rd_n_o [*2])
		else $error("read strobes too close");
	a_start_held: assert property (
		$fell(convert_start_n_o) |-> !convert_start_n_o [*3])
		else $error("start pulse too short");
endmodule

bind dacrc_ctrl dacrc_ctrl_sva u_sva (
	.mclk_i(mclk_i),
	.rst_n_i(rst_n_i),
	.convert_start_n_o(convert_start_n_o),
	.pair_select_o(pair_select_o),
	.cs_n_o(cs_n_o),
	.rd_n_o(rd_n_o),
	.busy_i(busy_i)
);

// >>> bench/dacrc_adc_model.sv
// Behavioural dual converter as seen at its pins
`timescale 1ns/10ps
module dacrc_adc_model #(
	parameter int CONV_NS = 5190,
	parameter int WAKE_NS = 4790,
	parameter int ACC_NS  = 10
) (
	// Converter pins
	input  wire logic        convert_start_n_i,
	input  wire logic        pair_select_i,
	input  wire logic        cs_n_i,
	input  wire logic        rd_n_i,
	output logic             busy_o,
	output logic [13:0]      db_o,
	// Input stand-ins: A first, A second, B first, B second
	input  wire logic [55:0] codes_i
);
	// ****************************************
	// Conversion and sleep
	// ****************************************
	logic [13:0] res [2];
	logic [13:0] last;
	logic        awake;
	logic        ptr;

	// Times sit off the clock edges to keep sampling free of races
	initial begin
		busy_o = 1'b0;
		awake = 1'b1;
		ptr = 1'b0;
		last = 14'h0000;
		db_o = 14'h3fff;
	end

	// Hold both inputs, convert, latch, then sleep if start is low
	task automatic convert();
		busy_o = 1'b1;
		res[0] = pair_select_i ? codes_i[27:14] : codes_i[55:42];
		res[1] = pair_select_i ? codes_i[13:0] : codes_i[41:28];
		#(CONV_NS);
		ptr = 1'b0;
		busy_o = 1'b0;
		awake = convert_start_n_i;
	endtask

	always @(negedge convert_start_n_i) begin
		if (awake) begin
			convert();
		end
	end

	// A start fall during wake-up waits for the wake-up to end
	always @(posedge convert_start_n_i) begin
		if (!awake) begin
			#(WAKE_NS);
			awake = 1'b1;
			if (!convert_start_n_i) begin
				convert();
			end
		end
	end

	// ****************************************
	// Read bus
	// ****************************************
	// Outside a strobe the bus shows the inverse of the last word
	always @(negedge rd_n_i) begin
		if (!cs_n_i && !busy_o) begin
			#(ACC_NS);
			last = res[ptr];
			db_o = last;
		end
	end

	always @(posedge rd_n_i) begin
		if (!cs_n_i) begin
			ptr = ~ptr;
		end
		db_o = ~last;
	end
endmodule

// >>> bench/dacrc_ctrl_tb_top.sv
// Self-checking bench for the dual converter controller
`timescale 1ns/10ps
module dacrc_ctrl_tb_top
	import dacrc_pkg::*;
;
	// ****************************************
	// Signals and instances
	// ****************************************
	logic        mclk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic        req_valid_i = 1'b0;
	dacrc_req_t  req_i = '0;
	logic        res_ready_i = 1'b1;
	logic        int_ref = 1'b0;
	logic [55:0] codes = '0;
	logic        req_ready_o, res_valid_o, convert_start_n_o;
	logic        pair_select_o, cs_n_o, rd_n_o, busy_i;
	logic [13:0] db_i;
	dacrc_word_t res_o;
	int          n_errors = 0;
	int          n_checks = 0;
	int          cycles = 0;
	int          kk = 0;

	dacrc_ctrl #(.WAKE_CYC(50), .FIFO_W(16), .FIFO_D(8)) dut (
		.mclk_i(mclk_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid_i),
		.req_i(req_i), .int_ref_i(int_ref), .req_ready_o(req_ready_o),
		.res_valid_o(res_valid_o), .res_ready_i(res_ready_i), .res_o(res_o),
		.convert_start_n_o(convert_start_n_o), .pair_select_o(pair_select_o),
		.cs_n_o(cs_n_o), .rd_n_o(rd_n_o), .busy_i(busy_i), .db_i(db_i));

	dacrc_adc_model u_adc (
		.convert_start_n_i(convert_start_n_o), .pair_select_i(pair_select_o),
		.cs_n_i(cs_n_o), .rd_n_i(rd_n_o), .busy_o(busy_i), .db_o(db_i),
		.codes_i(codes));

	// Clock and hang guard
	always #12.5 mclk_i = ~mclk_i;
	always @(posedge mclk_i) begin
		cycles++;
		if (cycles == 30000) begin
			n_errors++;
			results();
		end
	end

	// ****************************************
	// Helpers
	// ****************************************
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// A wait that runs out is a mismatch
	task automatic lim(input int n, input int max);
		if (n >= max) begin
			n_errors++;
			$display("CHECK FAILED at %0t got %h exp %h", $time, n, max - 1);
		end
	endtask

	function automatic logic [13:0] cv(input int k, input int i);
		return 14'((k * 4 + i) * 16'h0229 + 16'h1003);
	endfunction

	task automatic set_codes(input int k);
		codes = {cv(k, 0), cv(k, 1), cv(k, 2), cv(k, 3)};
	endtask

	// Request held until the edge that takes it
	task automatic send(input logic [3:0] r);
		int n;
		n = 0;
		@(posedge mclk_i);
		#2;
		req_valid_i = 1'b1;
		req_i = r;
		do begin
			@(posedge mclk_i);
			n++;
		end while (req_ready_o !== 1'b1 && n < 2000);
		lim(n, 2000);
		#2;
		req_valid_i = 1'b0;
	endtask

	task automatic wait_end();
		int n;
		n = 0;
		while (busy_i !== 1'b1 && n < 1000) begin
			@(posedge mclk_i);
			n++;
		end
		while (busy_i !== 1'b0 && n < 1000) begin
			@(posedge mclk_i);
			n++;
		end
		lim(n, 1000);
	endtask

	// Word taken at the edge where valid meets ready
	task automatic get(input int k, input logic s, input logic sec);
		int n;
		n = 0;
		do begin
			@(posedge mclk_i);
			n++;
		end while (res_valid_o !== 1'b1 && n < 2000);
		lim(n, 2000);
		chk(res_o, {s, sec, cv(k, s * 2 + sec)});
	endtask

	// One conversion; st is the start level due at its end, -1 skips
	task automatic conv(input logic [3:0] r, input int st);
		set_codes(kk);
		send(r);
		wait_end();
		if (st >= 0) chk(16'(convert_start_n_o), 16'(st));
		if (r[1]) get(kk, r[3], 1'b0);
		if (r[0]) get(kk, r[3], 1'b1);
		kk++;
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_pairs();
		conv(4'b0011, 1);
		conv(4'b1011, 1);
		$display("t_pairs done");
	endtask

	// Partial reads, then a full read after each
	task automatic t_partial();
		conv(4'b0010, 1);
		conv(4'b1011, 1);
		conv(4'b0001, 1);
		conv(4'b0011, 1);
		$display("t_partial done");
	endtask

	// Read while asleep, wake at once; then wake long before a request
	task automatic t_sleep();
		conv(4'b0111, 0);
		#2;
		int_ref = 1'b1;
		conv(4'b0011, 1);
		#2;
		int_ref = 1'b0;
		conv(4'b1111, 0);
		repeat (260) @(posedge mclk_i);
		conv(4'b1011, 1);
		$display("t_sleep done");
	endtask

	// Stall the consumer until the controller waits with select low
	task automatic t_fifo();
		int b;
		b = kk;
		@(posedge mclk_i);
		#2;
		res_ready_i = 1'b0;
		for (int i = 0; i < 5; i++) begin
			set_codes(b + i);
			send(4'b1011);
			wait_end();
		end
		repeat (40) @(posedge mclk_i);
		chk(16'({cs_n_o, req_ready_o}), 16'h0000);
		#2;
		res_ready_i = 1'b1;
		for (int i = 0; i < 5; i++) begin
			get(b + i, 1'b1, 1'b0);
			get(b + i, 1'b1, 1'b1);
		end
		kk = b + 5;
		repeat (4) @(posedge mclk_i);
		chk(16'(res_valid_o), 16'h0000);
		$display("t_fifo done");
	endtask

	task automatic results();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// Pins idle while reset is held, then the scenarios in turn
	initial begin
		repeat (2) @(posedge mclk_i);
		chk(16'({convert_start_n_o, cs_n_o, rd_n_o}), 16'h0007);
		chk(16'({pair_select_o, req_ready_o, res_valid_o}), 16'h0000);
		$display("t_reset done");
		#2;
		rst_n_i = 1'b1;
		t_pairs();
		t_partial();
		t_sleep();
		t_fifo();
		results();
	end
endmodule
